// ### dual_rx_diag_consts.svh
/*
 * Constants of the dual receiver diagnostic memory: two-wire device
 * addresses, byte offsets inside the monitoring areas, bit positions and
 * signal-loss detector timing.
 * Assumes clk_sys at 40 MHz; included by bare name.
 */
`ifndef DUAL_RX_DIAG_CONSTS_SVH
`define DUAL_RX_DIAG_CONSTS_SVH

// ==================================================================
// two-wire device addresses (8-bit form, write direction)
// ==================================================================
`define ID_AREA_ADDR        8'hA0
`define MON_FIRST_ADDR_DEF  8'hA2
`define MON_SECOND_ADDR_DEF 8'hA4

// ==================================================================
// monitoring area byte offsets
// ==================================================================
`define OFS_TEMP_MSB        8'h60
`define OFS_TEMP_LSB        8'h61
`define OFS_VCC_MSB         8'h62
`define OFS_VCC_LSB         8'h63
`define OFS_RXPWR_MSB       8'h68
`define OFS_RXPWR_LSB       8'h69
`define OFS_RX_STATUS       8'h6E
`define BIT_SIGNAL_ABSENT   1

// ==================================================================
// identification area contents
// ==================================================================
`define ID_BYTE0_OFS        8'h00
`define ID_BYTE0_VAL        8'h80
`define ID_BYTE1_OFS        8'h01
`define ID_BYTE1_VAL        8'h04
`define ID_BYTE2_OFS        8'h02
`define ID_BYTE2_VAL        8'h80
`define ID_ENC_OFS          8'h0B
`define ID_ENC_VAL          8'h03
`define ID_RATE_OFS         8'h0C
`define ID_RATE_VAL         8'h1E
`define ID_LENGTH_OFS       8'h0F
`define ID_LENGTH_VAL       8'h64
`define ID_OPTIONS_OFS      8'h41
`define ID_OPTIONS_VAL      8'h02

// ==================================================================
// signal-loss detector: transitions counted per observation window
// ==================================================================
`define CLK_PERIOD_NS       25
`define LOSS_WINDOW_NS      10000
`define LOSS_WINDOW_CYC     (`LOSS_WINDOW_NS / `CLK_PERIOD_NS)
`define LOSS_ASSERT_EDGES   10'h008
`define LOSS_CLEAR_EDGES    10'h010

`endif

// ### dual_rx_diag_pkg.sv
/*
 * Types of the dual receiver diagnostic memory.
 * Assumes nothing beyond the constants header.
 */
package dual_rx_diag_pkg;

   // ==================================================================
   // two-wire slave states
   // ==================================================================
   typedef enum logic [2:0] {
      SL_IDLE, SL_ADDR, SL_ADDR_ACK, SL_PTR, SL_PTR_ACK, SL_READ, SL_READ_ACK
   } slave_state_t;

   typedef enum logic [1:0] {
      AREA_ID, AREA_FIRST, AREA_SECOND
   } area_t;

   // calibrated monitor words, already in final units
   typedef struct packed {
      logic [15:0] temperature;
      logic [15:0] supply;
      logic [15:0] rxPowerFirst;
      logic [15:0] rxPowerSecond;
   } diag_words_t;

endpackage

// ### dual_rx_diag_memory.sv
/*
 * Two-wire diagnostic and identification memory of a dual optical receiver:
 * identification area, one monitoring area per receiver, and the
 * transition-based signal-loss detectors that drive the status pins.
 * Assumes calibrated monitor words from the analog front end on clk_sys,
 * and asynchronous pin inputs (bus lines, quantized receive data).
 */
// Overview of operation
// - each receiver's signal-absent pin is low while usable light is present and high when it is not.
// - signal loss is judged by counting data transitions, i.e. the ac activity, not the average level.
// - loss thresholds are fixed constants the host cannot change.
// - byte 110 bit 1 of each monitoring area mirrors that receiver's signal-absent state.
// - a 256-byte identification area answers at bus address A0h.
// - each receiver has its own 256-byte monitoring area, at A2h and A4h by default.
// - temperature, supply and received power are reported as already calibrated words.
// - a factory build option may move the monitoring pair to another address pair.
`timescale 1ns/1ps
`include "dual_rx_diag_consts.svh"

module dual_rx_diag_memory
   import dual_rx_diag_pkg::*;
#(
   parameter logic [7:0] MON_FIRST_ADDR = `MON_FIRST_ADDR_DEF   // factory address option
)(
   input  wire logic        clk_sys,                            // 40 MHz system clock
   input  wire logic        rst_n,                              // synchronous reset, active low
   input  wire logic        sclIn,                              // two-wire clock pin
   input  wire logic        sdaIn,                              // two-wire data pin, input
   output logic             sdaOut,                             // two-wire data pin, output level
   output logic             sdaOe,                              // two-wire data pin, drive enable
   input  wire logic [1:0]  rxDataIn,                           // quantized receive data per receiver
   input  diag_words_t      diagWords,                          // calibrated monitor words
   output logic [1:0]       receiverSignalAbsentPin             // signal-absent pins, high on loss
);

   // ==================================================================
   // pin synchronisers and filtered bus levels
   // ==================================================================
   logic [2:0]   sclSync_r;
   logic [2:0]   sdaSync_r;
   logic         sclF_r;
   logic         sdaF_r;
   logic         sclPrev_r;
   logic         sdaPrev_r;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sclSync_r <= 3'h7;
         sdaSync_r <= 3'h7;
         sclF_r    <= 1'b1;
         sdaF_r    <= 1'b1;
         sclPrev_r <= 1'b1;
         sdaPrev_r <= 1'b1;
      end else begin
         sclSync_r <= {sclSync_r[1:0], sclIn};
         sdaSync_r <= {sdaSync_r[1:0], sdaIn};
         if (sclSync_r[1] == sclSync_r[2]) begin
            sclF_r <= sclSync_r[2];
         end
         if (sdaSync_r[1] == sdaSync_r[2]) begin
            sdaF_r <= sdaSync_r[2];
         end
         sclPrev_r <= sclF_r;
         sdaPrev_r <= sdaF_r;
      end
   end

   logic sclRise;
   logic sclFall;
   logic busStart;
   logic busStop;

   assign sclRise  = sclF_r & ~sclPrev_r;
   assign sclFall  = ~sclF_r & sclPrev_r;
   assign busStart = sclF_r & sclPrev_r & sdaPrev_r & ~sdaF_r;
   assign busStop  = sclF_r & sclPrev_r & ~sdaPrev_r & sdaF_r;

   // ==================================================================
   // signal-loss detectors, one per receiver
   // ==================================================================
   wire logic [1:0] lossState_r;   // gathered per-receiver loss flops, one driver per bit

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : gLoss
         logic [2:0]  dSync_r;
         logic        dLast_r;
         logic [9:0]  edgeCnt_r;
         logic [15:0] winCnt_r;
         logic        lossBit_r;

         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               dSync_r        <= 3'h0;
               dLast_r        <= 1'b0;
               edgeCnt_r      <= 10'h000;
               winCnt_r       <= 16'h0000;
               lossBit_r      <= 1'b1;
            end else begin
               dSync_r <= {dSync_r[1:0], rxDataIn[gi]};
               if (dSync_r[1] == dSync_r[2]) begin
                  dLast_r <= dSync_r[2];
               end
               if (winCnt_r == 16'(`LOSS_WINDOW_CYC - 1)) begin
                  winCnt_r  <= 16'h0000;
                  edgeCnt_r <= 10'h000;
                  // hysteresis between fixed assert and clear levels
                  if (edgeCnt_r < `LOSS_ASSERT_EDGES) begin
                     lossBit_r <= 1'b1;
                  end else if (edgeCnt_r >= `LOSS_CLEAR_EDGES) begin
                     lossBit_r <= 1'b0;
                  end
               end else begin
                  winCnt_r <= winCnt_r + 16'h0001;
                  // count ac transitions only, saturating
                  if ((dSync_r[1] == dSync_r[2]) && (dSync_r[2] != dLast_r) && (edgeCnt_r != 10'h3FF)) begin
                     edgeCnt_r <= edgeCnt_r + 10'h001;
                  end
               end
            end
         end
         assign lossState_r[gi] = lossBit_r;
      end
   endgenerate

   assign receiverSignalAbsentPin = lossState_r;

   // ==================================================================
   // byte read mux
   // ==================================================================
   function automatic logic [7:0] readByte(input area_t area, input logic [7:0] ofs,
                                           input diag_words_t w, input logic [1:0] loss);
      logic [7:0]  res;
      logic [15:0] pwr;
      res = 8'h00;
      pwr = (area == AREA_FIRST) ? w.rxPowerFirst : w.rxPowerSecond;
      if (area == AREA_ID) begin
         case (ofs)
            `ID_BYTE0_OFS:   res = `ID_BYTE0_VAL;
            `ID_BYTE1_OFS:   res = `ID_BYTE1_VAL;
            `ID_BYTE2_OFS:   res = `ID_BYTE2_VAL;
            `ID_ENC_OFS:     res = `ID_ENC_VAL;
            `ID_RATE_OFS:    res = `ID_RATE_VAL;
            `ID_LENGTH_OFS:  res = `ID_LENGTH_VAL;
            `ID_OPTIONS_OFS: res = `ID_OPTIONS_VAL;
            default:         res = 8'h00;
         endcase
      end else begin
         case (ofs)
            `OFS_TEMP_MSB:  res = w.temperature[15:8];
            `OFS_TEMP_LSB:  res = w.temperature[7:0];
            `OFS_VCC_MSB:   res = w.supply[15:8];
            `OFS_VCC_LSB:   res = w.supply[7:0];
            `OFS_RXPWR_MSB: res = pwr[15:8];
            `OFS_RXPWR_LSB: res = pwr[7:0];
            `OFS_RX_STATUS: res[`BIT_SIGNAL_ABSENT] = (area == AREA_FIRST) ? loss[0] : loss[1];
            default:        res = 8'h00;
         endcase
      end
      return res;
   endfunction

   // ==================================================================
   // two-wire slave
   // ==================================================================
   slave_state_t state_r;
   area_t        area_r;
   logic [7:0]   shift_r;
   logic [3:0]   bitCnt_r;
   logic [7:0]   ptr_r;
   logic [7:0]   txByte_r;
   logic         isRead_r;
   logic         hostAck_r;
   logic         sdaOe_r;
   logic [7:0]   monSecondAddr;
   logic [7:0]   curByte;
   logic [7:0]   nextByte;

   assign monSecondAddr = MON_FIRST_ADDR + 8'h02;
   // snapshot taken as the first byte of a read starts, so the status is current
   assign curByte = readByte(area_r, ptr_r, diagWords, lossState_r);
   // byte after the pointer, for sequential reads
   assign nextByte = readByte(area_r, ptr_r + 8'h01, diagWords, lossState_r);

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_r   <= SL_IDLE;
         area_r    <= AREA_ID;
         shift_r   <= 8'h00;
         bitCnt_r  <= 4'h0;
         ptr_r     <= 8'h00;
         txByte_r  <= 8'h00;
         isRead_r  <= 1'b0;
         hostAck_r <= 1'b0;
         sdaOe_r   <= 1'b0;
      end else if (busStop) begin
         state_r <= SL_IDLE;
         sdaOe_r <= 1'b0;
      end else if (busStart) begin
         state_r  <= SL_ADDR;
         bitCnt_r <= 4'h0;
         sdaOe_r  <= 1'b0;
      end else begin
         if (sclRise) begin
            shift_r   <= {shift_r[6:0], sdaF_r};
            hostAck_r <= ~sdaF_r;
            if (bitCnt_r != 4'h8) begin
               bitCnt_r <= bitCnt_r + 4'h1;
            end
         end
         if (sclFall) begin
            case (state_r)
               SL_ADDR: begin
                  if (bitCnt_r == 4'h8) begin
                     isRead_r <= shift_r[0];
                     if ({shift_r[7:1], 1'b0} == `ID_AREA_ADDR) begin
                        area_r <= AREA_ID;
                        state_r <= SL_ADDR_ACK;
                        sdaOe_r <= 1'b1;
                     end else if ({shift_r[7:1], 1'b0} == MON_FIRST_ADDR) begin
                        area_r <= AREA_FIRST;
                        state_r <= SL_ADDR_ACK;
                        sdaOe_r <= 1'b1;
                     end else if ({shift_r[7:1], 1'b0} == monSecondAddr) begin
                        area_r <= AREA_SECOND;
                        state_r <= SL_ADDR_ACK;
                        sdaOe_r <= 1'b1;
                     end else begin
                        state_r <= SL_IDLE;
                     end
                  end
               end
               SL_ADDR_ACK: begin
                  bitCnt_r <= 4'h0;
                  if (isRead_r) begin
                     state_r  <= SL_READ;
                     txByte_r <= curByte;
                     sdaOe_r  <= ~curByte[7];
                  end else begin
                     state_r <= SL_PTR;
                     sdaOe_r <= 1'b0;
                  end
               end
               SL_PTR: begin
                  if (bitCnt_r == 4'h8) begin
                     ptr_r   <= shift_r;
                     state_r <= SL_PTR_ACK;
                     sdaOe_r <= 1'b1;
                  end
               end
               SL_PTR_ACK: begin
                  // later write bytes are acknowledged and each one reloads the pointer; nothing else is written
                  bitCnt_r <= 4'h0;
                  state_r  <= SL_PTR;
                  sdaOe_r  <= 1'b0;
               end
               SL_READ: begin
                  if (bitCnt_r == 4'h8) begin
                     state_r <= SL_READ_ACK;
                     sdaOe_r <= 1'b0;
                  end else begin
                     sdaOe_r <= ~txByte_r[3'(4'h7 - bitCnt_r)];
                  end
               end
               SL_READ_ACK: begin
                  bitCnt_r <= 4'h0;
                  if (hostAck_r) begin
                     // sequential read: next byte, wrapping in the 256-byte area
                     ptr_r    <= ptr_r + 8'h01;
                     txByte_r <= nextByte;
                     sdaOe_r  <= ~nextByte[7];
                     state_r  <= SL_READ;
                  end else begin
                     ptr_r   <= ptr_r + 8'h01;
                     state_r <= SL_IDLE;
                  end
               end
               default: begin
                  state_r <= SL_IDLE;
                  sdaOe_r <= 1'b0;
               end
            endcase
         end
      end
   end

   assign sdaOut = 1'b0;
   assign sdaOe  = sdaOe_r;

endmodule // dual_rx_diag_memory

// ### dual_rx_diag_memory_properties.sv
/*
 * Checker of the dual receiver diagnostic memory: reset levels, signal-loss
 * pin behaviour and two-wire data line drive.
 * Assumes it is bound to dual_rx_diag_memory and sees its ports only.
 */
`timescale 1ns/1ps
module dual_rx_diag_memory_properties
   import dual_rx_diag_pkg::*;
(
   input wire logic        clk_sys,                  // system clock
   input wire logic        rst_n,                    // synchronous reset
   input wire logic        sclIn,                    // bus clock pin
   input wire logic        sdaIn,                    // bus data pin
   input wire logic        sdaOut,                   // data output level
   input wire logic        sdaOe,                    // data drive enable
   input wire logic [1:0]  rxDataIn,                 // receive data
   input wire diag_words_t diagWords,                // monitor words
   input wire logic [1:0]  receiverSignalAbsentPin   // loss pins
);
   // ==================================================================
   // helper counters: quiet and busy time per receiver, pin age
   // ==================================================================
   logic [1:0]  rxPrev_r;
   logic [1:0]  pinPrev_r;
   logic [11:0] quietCnt_r [2];
   logic [11:0] busyCnt_r  [2];
   logic [11:0] sinceChg_r;

   always_ff @(posedge clk_sys) begin
      rxPrev_r <= rxDataIn;
      for (int r = 0; r < 2; r++) begin
         if (!rst_n || rxDataIn[r] != rxPrev_r[r]) quietCnt_r[r] <= '0;
         else if (quietCnt_r[r] != 12'hFFF) quietCnt_r[r] <= quietCnt_r[r] + 12'h001;
         if (!rst_n || quietCnt_r[r] > 12'h00C) busyCnt_r[r] <= '0;
         else if (busyCnt_r[r] != 12'hFFF) busyCnt_r[r] <= busyCnt_r[r] + 12'h001;
      end
   end

   always_ff @(posedge clk_sys) begin
      pinPrev_r <= receiverSignalAbsentPin;
      if (!rst_n || receiverSignalAbsentPin != pinPrev_r) sinceChg_r <= '0;
      else if (sinceChg_r != 12'hFFF) sinceChg_r <= sinceChg_r + 12'h001;
   end

   // ==================================================================
   // assertions
   // ==================================================================
   a_reset_pins_lost: assert property (@(posedge clk_sys) !rst_n |=> receiverSignalAbsentPin == 2'b11)
      else $error("loss pins not high after reset");
   a_reset_sda_idle: assert property (@(posedge clk_sys) !rst_n |=> !sdaOe)
      else $error("data line driven after reset");
   a_sda_open_drain: assert property (@(posedge clk_sys) disable iff (!rst_n) sdaOut == 1'b0)
      else $error("data output level not low");
   a_quiet_first_lost: assert property (@(posedge clk_sys) disable iff (!rst_n)
      quietCnt_r[0] >= 12'h340 |-> receiverSignalAbsentPin[0])
      else $error("first pin low without activity");
   a_quiet_second_lost: assert property (@(posedge clk_sys) disable iff (!rst_n)
      quietCnt_r[1] >= 12'h340 |-> receiverSignalAbsentPin[1])
      else $error("second pin low without activity");
   a_busy_first_ok: assert property (@(posedge clk_sys) disable iff (!rst_n)
      busyCnt_r[0] >= 12'h340 |-> !receiverSignalAbsentPin[0])
      else $error("first pin high with activity");
   a_busy_second_ok: assert property (@(posedge clk_sys) disable iff (!rst_n)
      busyCnt_r[1] >= 12'h340 |-> !receiverSignalAbsentPin[1])
      else $error("second pin high with activity");
   a_pin_window_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      receiverSignalAbsentPin != pinPrev_r |-> sinceChg_r >= 12'h186)
      else $error("loss pin changed inside a window");
   a_ack_scl_low: assert property (@(posedge clk_sys) disable iff (!rst_n) $rose(sdaOe) |-> !sclIn)
      else $error("data drive started while clock high");
   a_stop_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(sdaIn) && sclIn |-> ##[1:10] !sdaOe)
      else $error("data line held after stop");
endmodule // dual_rx_diag_memory_properties

bind dual_rx_diag_memory dual_rx_diag_memory_properties u_props (.clk_sys(clk_sys), .rst_n(rst_n),
   .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .rxDataIn(rxDataIn),
   .diagWords(diagWords), .receiverSignalAbsentPin(receiverSignalAbsentPin));

// ### dual_rx_host_model.sv
/*
 * Host two-wire controller model: random reads of one to four bytes.
 * Assumes a pulled-up data line resolved outside; host is sole clock master.
 */
`timescale 1ns/1ps
module dual_rx_host_model (
   input  wire logic clk_sys,   // system clock
   input  wire logic sdaLine,   // resolved data line
   output logic      sclLine,   // bus clock
   output logic      sdaLow     // high while host pulls data low
);
   initial begin
      sclLine = 1'b1;
      sdaLow = 1'b0;
   end

   task automatic hold();
      repeat (10) @(posedge clk_sys);
   endtask

   // start and repeated start
   task automatic busStart();
      sdaLow <= 1'b0;
      hold();
      sclLine <= 1'b1;
      hold();
      sdaLow <= 1'b1;
      hold();
      sclLine <= 1'b0;
      hold();
   endtask

   task automatic busStop();
      sdaLow <= 1'b1;
      hold();
      sclLine <= 1'b1;
      hold();
      sdaLow <= 1'b0;
      hold();
   endtask

   // data set while clock low, sampled at end of high phase
   task automatic bitCycle(input logic b, output logic s);
      sdaLow <= ~b;
      hold();
      sclLine <= 1'b1;
      hold();
      s = sdaLine;
      sclLine <= 1'b0;
      hold();
   endtask

   task automatic xferByte(input logic [7:0] tx, input logic ackBit, output logic [7:0] rx, output logic ackSeen);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitCycle(tx[i], s);
         rx[i] = s;
      end
      bitCycle(ackBit, s);
      ackSeen = ~s;
   endtask

   // pointer write, repeated start, sequential read ended by nack
   task automatic readAt(input logic [7:0] dev, input logic [7:0] ofs, input int n,
                         output logic [31:0] data, output logic acked);
      logic [7:0] rx;
      logic       a0, a1, a2, ad;
      data = '0;
      busStart();
      xferByte(dev, 1'b1, rx, a0);
      xferByte(ofs, 1'b1, rx, a1);
      busStart();
      xferByte(dev | 8'h01, 1'b1, rx, a2);
      for (int k = 0; k < n; k++) begin
         xferByte(8'hFF, k == n - 1, rx, ad);
         data = {data[23:0], rx};
      end
      busStop();
      acked = a0 & a1 & a2;
   endtask
endmodule // dual_rx_host_model

// ### tb_dual_rx_diag_memory.sv
/*
 * Testbench of the dual receiver diagnostic memory: identification and
 * monitor reads, signal-loss pins and mirrored status, foreign address.
 * Assumes the host model drives the bus; data line pulled up here.
 */
`timescale 1ns/1ps
module tb_dual_rx_diag_memory;
   import dual_rx_diag_pkg::*;
   localparam logic [7:0]  ID_OFS [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0B, 8'h0C, 8'h0F, 8'h41};
   localparam logic [7:0]  ID_VAL [8] = '{8'h80, 8'h04, 8'h80, 8'h00, 8'h03, 8'h1E, 8'h64, 8'h02};
   localparam logic [7:0]  MON_DEV [5] = '{8'hA2, 8'hA2, 8'hA2, 8'hA4, 8'hA4};
   localparam logic [7:0]  MON_OFS [5] = '{8'h60, 8'h62, 8'h68, 8'h60, 8'h68};
   localparam logic [15:0] MON_EXP [5] = '{16'h1A2B, 16'h3C4D, 16'h5E6F, 16'h1A2B, 16'h7081};
   localparam logic [1:0]  ACT [4] = '{2'b00, 2'b11, 2'b10, 2'b01};

   logic        clk_sys   = 1'b0;
   logic        rst_n     = 1'b0;
   logic [1:0]  rxDataIn  = 2'b00;
   logic [1:0]  rxActive  = 2'b00;
   logic [2:0]  divCnt    = 3'h0;
   diag_words_t diagWords = diag_words_t'(64'h1A2B_3C4D_5E6F_7081);
   logic        sclLine, sdaLow, sdaOut, sdaOe;
   logic        sdaOutAlt, sdaOeAlt;
   logic [1:0]  absentPinsAlt;
   logic [1:0]  absentPins;
   int          n_fail = 0;
   int          total_checks = 0;
   wire logic   sdaLine = ~(sdaLow | (sdaOe & ~sdaOut) | (sdaOeAlt & ~sdaOutAlt));

   always #12.5 clk_sys = ~clk_sys;

   // active receivers toggle every 8 cycles
   always @(posedge clk_sys) begin
      divCnt <= divCnt + 3'h1;
      if (divCnt == 3'h7)
         rxDataIn <= rxDataIn ^ rxActive;
   end

   dual_rx_diag_memory u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .sclIn(sclLine), .sdaIn(sdaLine),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .rxDataIn(rxDataIn), .diagWords(diagWords),
      .receiverSignalAbsentPin(absentPins));
   // factory option: monitor pair moved to C2h/C4h, shares the bus
   dual_rx_diag_memory #(.MON_FIRST_ADDR(8'hC2)) u_dut_alt (.clk_sys(clk_sys), .rst_n(rst_n), .sclIn(sclLine),
      .sdaIn(sdaLine), .sdaOut(sdaOutAlt), .sdaOe(sdaOeAlt), .rxDataIn(rxDataIn), .diagWords(diagWords),
      .receiverSignalAbsentPin(absentPinsAlt));
   dual_rx_host_model u_host (.clk_sys(clk_sys), .sdaLine(sdaLine), .sclLine(sclLine), .sdaLow(sdaLow));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      logic [31:0] d;
      logic        ok;
      repeat (6) @(posedge clk_sys);
      check("pins in reset", 32'(absentPins), 32'h3);
      check("sda in reset", 32'(sdaOe), 32'h0);
      rst_n <= 1'b1;
      repeat (20) @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
         u_host.readAt(8'hA0, ID_OFS[i], 1, d, ok);
         check("id byte", 32'({ok, d[7:0]}), 32'({1'b1, ID_VAL[i]}));
      end
      $display("test id area done");
      for (int i = 0; i < 5; i++) begin
         u_host.readAt(MON_DEV[i], MON_OFS[i], 2, d, ok);
         check("monitor word", 32'({ok, d[15:0]}), 32'({1'b1, MON_EXP[i]}));
      end
      $display("test monitor words done");
      u_host.readAt(8'hA6, 8'h00, 1, d, ok);
      check("foreign address", 32'({ok, d[7:0]}), 32'h0FF);
      $display("test foreign address done");
      u_host.readAt(8'hC2, 8'h60, 2, d, ok);
      check("alt first word", 32'({ok, d[15:0]}), 32'({1'b1, 16'h1A2B}));
      u_host.readAt(8'hC4, 8'h68, 2, d, ok);
      check("alt second word", 32'({ok, d[15:0]}), 32'({1'b1, 16'h7081}));
      $display("test alternate addresses done");
      for (int s = 0; s < 4; s++) begin
         rxActive <= ACT[s];
         repeat (1200) @(posedge clk_sys);
         check("loss pins", 32'(absentPins), {30'h0, ~ACT[s]});
         check("alt loss pins", 32'(absentPinsAlt), {30'h0, ~ACT[s]});
         u_host.readAt(8'hA2, 8'h6E, 1, d, ok);
         check("first status bit", 32'({ok, d[1]}), 32'({1'b1, ~ACT[s][0]}));
         u_host.readAt(8'hA4, 8'h6E, 1, d, ok);
         check("second status bit", 32'({ok, d[1]}), 32'({1'b1, ~ACT[s][1]}));
      end
      $display("test signal loss done");
      finish_test();
   end
endmodule // tb_dual_rx_diag_memory
